/* File: verilog/fms_pkg.sv */
// shared constants and types of the fir microcode sequencer
package fms_pkg;
    localparam int STEPS = 32;
    localparam int IP_W = 5;
    localparam int IW = 128;
    localparam int DRAM_DEPTH = 384;
    localparam int CRAM_DEPTH = 192;
    localparam logic [4:0] IP_RESET = 5'h1F;
    // opcode field and its flag positions
    localparam int OP_LSB = 0;
    localparam int OP_W = 9;
    localparam int F_START = 6;
    localparam int F_INCR_RS = 5;
    localparam int F_DECR_SEL = 4;
    localparam int F_DECR_EN = 3;
    localparam int F_LD_LP = 2;
    localparam int F_DECR_LP = 1;
    // filter parameter fields
    localparam int TAPS_LSB = 9;
    localparam int TYPE_LSB = 18;
    localparam int DECIM_LSB = 20;
    localparam int BLOG_LSB = 24;
    localparam int BBASE_LSB = 28;
    localparam int CBASE_LSB = 37;
    localparam int NOUT_LSB = 45;
    localparam int POLY_BIT = 49;
    localparam int TO_OUT_BIT = 50;
    localparam int SRC_CHAIN_BIT = 51;
    localparam int LOOP_LSB = 64;
    localparam logic [3:0] BLOG_MAX = 4'h8;
    // filter types
    localparam logic [1:0] FT_SYM = 2'h0;
    localparam logic [1:0] FT_HALFBAND = 2'h1;
    localparam logic [1:0] FT_NONSYM = 2'h2;
    // condition codes
    localparam logic [2:0] CC_WAIT_LT = 3'h0;
    localparam logic [2:0] CC_WAIT_GE = 3'h1;
    localparam logic [2:0] CC_LOOP_NZ = 3'h2;
    localparam logic [2:0] CC_LOOP_Z = 3'h3;
    localparam logic [2:0] CC_NO_CARRY = 3'h4;
    localparam logic [2:0] CC_CARRY = 3'h5;
    localparam logic [2:0] CC_SYNC = 3'h6;
    // host address fields, rom coefficient, output shift and fifo depth
    localparam int HA_CHAN_LSB = 12;
    localparam int HA_PAT_LSB = 7;
    localparam logic [4:0] HA_INSTR_PAT = 5'h02;
    localparam logic [3:0] HA_COEF_PAT = 4'h3;
    localparam logic signed [15:0] ROM_COEF = 16'sh1000;
    localparam int OUT_SHIFT = 12;
    localparam int FIFO_DEPTH = 16;

    typedef struct packed {
        logic signed [15:0] re;
        logic signed [15:0] im;
    } fms_cplx_t;

    typedef struct packed {
        fms_cplx_t data;
        logic [1:0] phase;
    } fms_out_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [31:0] data;
    } fms_host_t;

    typedef enum logic [2:0] {
        S_HOLD = 3'b001,
        S_STEP = 3'b010,
        S_CALC = 3'b100
    } fms_state_t;
endpackage

/* File: verilog/fms_sequencer.sv */
// sample fifo and fir microcode sequencer of one channel
// Notes on behaviour
// - program of up to 32 steps, 5-bit pointer
// - step is filter, wait, jump, loop load, nop
// - 128-bit words, unused bits ignored per type
// - nine opcode bits; rest parameters or loop preload
// - four 32-bit writes build one step
// - filter reset puts pointer at step 31
// - filter reset initialises data ram pointers
// - one filter's read start gets fixed offset
// - host address: channel, 00010, step, lane
// - ram access only while hold bit set
// - one clock per accepted input sample write
// - wait and jump cost one clock each
// - symmetric filters pre-add, two taps per clock
// - nonsymmetric filters take one clock per tap
// - halfband skips zero coefficients, fewer clocks
// - wait holds for samples; filter adjusts count
// - halfband and resampler coefficients from rom
// - polyphase offset reads, tagged interleaved outputs
// - one channel's gain may drive all
// - shared gain: error from every fourth output
// - three-bit condition code selects jump/wait test
// - ten-bit wait threshold sample count
// - 384-pair data ram, blocks up to 256
`timescale 1ns/1ns

module fms_fifo #(
    parameter int W = 32,
    parameter int DEPTH = 16
) (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic clk_en_i,
    input wire logic clear_i,
    input wire logic in_valid_i,
    input wire logic [W-1:0] in_data_i,
    output logic in_ready_o,
    output logic out_valid_o,
    output logic [W-1:0] out_data_o,
    input wire logic out_ready_i
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
    localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);
    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    wire full = ~in_ready_o;
    logic empty;
    wire push = in_valid_i & ~full;
    wire pop = ~empty & out_ready_i;
    wire [AW:0] next_count = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    wire [AW-1:0] next_wr = (wr_ptr == LAST_PTR) ? '0 : wr_ptr + 1'b1;
    wire [AW-1:0] next_rd = (rd_ptr == LAST_PTR) ? '0 : rd_ptr + 1'b1;
    assign out_valid_o = ~empty;
    assign out_data_o = mem[rd_ptr];

    always_ff @(posedge clock_i) begin
        if (clk_en_i && push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
            in_ready_o <= 1'b1;
            empty <= 1'b1;
        end else if (clk_en_i) begin
            if (clear_i) begin
                wr_ptr <= '0;
                rd_ptr <= '0;
                count <= '0;
                in_ready_o <= 1'b1;
                empty <= 1'b1;
            end else begin
                wr_ptr <= push ? next_wr : wr_ptr;
                rd_ptr <= pop ? next_rd : rd_ptr;
                count <= next_count;
                in_ready_o <= next_count != FULL_CNT;
                empty <= next_count == '0;
            end
        end
    end
endmodule

module fms_sequencer #(
    parameter int FIFO_DEPTH = fms_pkg::FIFO_DEPTH
) (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic clk_en_i,
    input wire logic filter_reset_i,
    input wire logic host_ram_access_hold_i,
    input wire logic [3:0] chan_id_i,
    input wire logic host_wr_i,
    input wire logic host_rd_i,
    input wire fms_pkg::fms_host_t host_req_i,
    output logic [31:0] host_rdata_o,
    output logic host_rvalid_o,
    input wire logic sample_valid_i,
    input wire fms_pkg::fms_cplx_t sample_i,
    output logic sample_ready_o,
    output logic out_valid_o,
    output fms_pkg::fms_out_t out_o,
    input wire logic out_ready_i,
    input wire logic [9:0] wait_threshold_i,
    input wire logic [7:0] read_offset_i,
    input wire logic [1:0] phase_i,
    input wire logic sync_i,
    input wire logic sync_en_i,
    input wire logic host_cond_i,
    input wire logic resampler_carry_out_i,
    input wire logic [15:0] own_gain_i,
    input wire logic [15:0] shared_gain_i,
    input wire logic share_gain_i,
    output logic [15:0] forward_gain_o,
    output logic gain_err_en_o,
    output logic resampler_step_o,
    output logic [4:0] step_o,
    output logic [9:0] wait_count_o
);
    // ----------------------------------------
    // storage
    // ----------------------------------------
    // 32-step store
    logic [fms_pkg::IW-1:0] istore [fms_pkg::STEPS];
    fms_pkg::fms_cplx_t dram [fms_pkg::DRAM_DEPTH];
    logic signed [15:0] cram [fms_pkg::CRAM_DEPTH];
    logic [7:0] wptr [fms_pkg::STEPS];
    fms_pkg::fms_state_t st;
    logic [3:0] wr_cnt;
    logic [8:0] calc_cnt;
    logic [3:0] out_cnt;
    logic [9:0] loop_cnt;
    logic [1:0] agc_seq;
    logic signed [39:0] acc_re;
    logic signed [39:0] acc_im;
    logic sync_meta;
    logic sync_s;

    // wraps a block address into the data ram
    function automatic logic [8:0] fms_wrap(input logic [8:0] base, input logic [7:0] off);
        logic [9:0] sum;
        sum = {1'b0, base} + {2'b00, off};
        if (sum >= 10'(fms_pkg::DRAM_DEPTH)) begin
            sum = sum - 10'(fms_pkg::DRAM_DEPTH);
        end
        return sum[8:0];
    endfunction

    // ----------------------------------------
    // host access
    // ----------------------------------------
    // address decode
    wire host_sel = host_req_i.addr[fms_pkg::HA_CHAN_LSB +: 4] == chan_id_i;
    wire instr_hit = host_req_i.addr[fms_pkg::HA_PAT_LSB +: 5] == fms_pkg::HA_INSTR_PAT;
    wire coef_hit = host_req_i.addr[11:8] == fms_pkg::HA_COEF_PAT;
    wire host_ok = host_sel & host_ram_access_hold_i;
    wire [4:0] h_step = host_req_i.addr[6:2];
    wire [1:0] h_lane = host_req_i.addr[1:0];
    wire [7:0] h_cidx = host_req_i.addr[7:0];
    wire h_cok = h_cidx < 8'(fms_pkg::CRAM_DEPTH);
    wire [fms_pkg::IW-1:0] h_word = istore[h_step];

    always_ff @(posedge clock_i) begin
        if (clk_en_i && host_wr_i && host_ok) begin
            if (instr_hit) begin
                istore[h_step][{h_lane, 5'b00000} +: 32] <= host_req_i.data;
            end else if (coef_hit && h_cok) begin
                cram[h_cidx] <= host_req_i.data[15:0];
            end
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            host_rdata_o <= 32'h00000000;
            host_rvalid_o <= 1'b0;
        end else if (clk_en_i) begin
            host_rvalid_o <= host_rd_i & host_ok & (instr_hit | coef_hit);
            if (host_rd_i && host_ok && instr_hit) begin
                host_rdata_o <= h_word[{h_lane, 5'b00000} +: 32];
            end else if (host_rd_i && host_ok && coef_hit) begin
                host_rdata_o <= h_cok ? {{16{cram[h_cidx][15]}}, cram[h_cidx]} : 32'h00000000;
            end
        end
    end

    // ----------------------------------------
    // instruction decode
    // ----------------------------------------
    wire [fms_pkg::IW-1:0] iword = istore[step_o];
    wire [8:0] op = iword[fms_pkg::OP_LSB +: fms_pkg::OP_W];
    wire is_jump = op[8];
    wire is_wait = op[8:7] == 2'b00;
    wire is_fir = op[8:7] == 2'b01;
    wire fir_start = op[fms_pkg::F_START];
    wire [8:0] taps = iword[fms_pkg::TAPS_LSB +: 9];
    wire [1:0] ftype = iword[fms_pkg::TYPE_LSB +: 2];
    wire [3:0] decim = iword[fms_pkg::DECIM_LSB +: 4];
    wire [3:0] blog_raw = iword[fms_pkg::BLOG_LSB +: 4];
    wire [8:0] blk_base = iword[fms_pkg::BBASE_LSB +: 9];
    wire [7:0] coef_base = iword[fms_pkg::CBASE_LSB +: 8];
    wire [3:0] nout = iword[fms_pkg::NOUT_LSB +: 4];
    wire poly_en = iword[fms_pkg::POLY_BIT];
    wire to_out = iword[fms_pkg::TO_OUT_BIT];
    wire src_chain = iword[fms_pkg::SRC_CHAIN_BIT];
    wire [9:0] loop_pre = iword[fms_pkg::LOOP_LSB +: 10];
    wire [3:0] blog = (blog_raw > fms_pkg::BLOG_MAX) ? fms_pkg::BLOG_MAX : blog_raw;
    wire [8:0] mask9 = (9'h001 << blog) - 9'h001;
    wire [7:0] blk_mask = mask9[7:0];

    logic cond;
    always_comb begin
        case (op[2:0])
            fms_pkg::CC_WAIT_LT: cond = wait_count_o < wait_threshold_i;
            fms_pkg::CC_WAIT_GE: cond = wait_count_o >= wait_threshold_i;
            fms_pkg::CC_LOOP_NZ: cond = loop_cnt != 10'h000;
            fms_pkg::CC_LOOP_Z: cond = loop_cnt == 10'h000;
            fms_pkg::CC_NO_CARRY: cond = ~resampler_carry_out_i;
            fms_pkg::CC_CARRY: cond = resampler_carry_out_i;
            fms_pkg::CC_SYNC: cond = sync_en_i ? sync_s : host_cond_i;
            default: cond = 1'b1;
        endcase
    end

    // ----------------------------------------
    // cycle budget per output
    // ----------------------------------------
    wire [9:0] taps_p1 = {1'b0, taps} + 10'h001;
    wire [9:0] taps_p5 = {1'b0, taps} + 10'h005;
    wire [8:0] sym_cyc = taps_p1[9:1];
    wire [8:0] hb_cyc = {1'b0, taps_p5[9:2]};
    wire [8:0] ncyc_raw = (ftype == fms_pkg::FT_HALFBAND) ? hb_cyc : (ftype == fms_pkg::FT_SYM) ? sym_cyc : taps;
    wire [8:0] ncyc = (ncyc_raw == 9'h000) ? 9'h001 : ncyc_raw;
    wire [3:0] nout_c = (nout == 4'h0) ? 4'h1 : nout;

    // ----------------------------------------
    // sample sources
    // ----------------------------------------
    fms_pkg::fms_cplx_t in_data;
    fms_pkg::fms_cplx_t ch_data;
    logic in_valid;
    logic ch_valid;
    logic ch_ready;
    wire run = (st != fms_pkg::S_HOLD) & ~host_ram_access_hold_i & ~filter_reset_i;
    wire in_step = run & (st == fms_pkg::S_STEP);
    wire in_calc = run & (st == fms_pkg::S_CALC);
    wire fir_go = in_step & is_fir & fir_start;
    wire src_valid = src_chain ? ch_valid : in_valid;
    wire wr_go = fir_go & (decim != 4'h0) & src_valid;
    wire wr_last = wr_go & (wr_cnt == decim - 4'h1);
    wire no_wr = fir_go & (decim == 4'h0);
    wire in_pop = wr_go & ~src_chain;
    wire ch_pop = wr_go & src_chain;
    wire in_push = sample_valid_i & sample_ready_o;
    fms_pkg::fms_cplx_t wr_data;
    assign wr_data = src_chain ? ch_data : in_data;

    fms_fifo #(.W($bits(fms_pkg::fms_cplx_t)), .DEPTH(FIFO_DEPTH)) u_in_fifo (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .clk_en_i(clk_en_i),
        .clear_i(filter_reset_i),
        .in_valid_i(sample_valid_i),
        .in_data_i(sample_i),
        .in_ready_o(sample_ready_o),
        .out_valid_o(in_valid),
        .out_data_o(in_data),
        .out_ready_i(in_pop)
    );

    // ----------------------------------------
    // datapath
    // ----------------------------------------
    wire [7:0] cur_wptr = wptr[step_o];
    wire [7:0] rd_newest = cur_wptr - 8'h01 + (poly_en ? read_offset_i : 8'h00);
    wire [7:0] center = 8'(taps_p1[9:1] - 9'h001);
    wire calc_end = calc_cnt == ncyc - 9'h001;
    wire [7:0] k_hb = calc_end ? center : {calc_cnt[6:0], 1'b0};
    wire [7:0] tap_k = (ftype == fms_pkg::FT_HALFBAND) ? k_hb : calc_cnt[7:0];
    wire [7:0] tap_m = taps[7:0] - 8'h01 - tap_k;
    wire b_use = (ftype != fms_pkg::FT_NONSYM) & (tap_k != tap_m);
    wire [8:0] wr_addr = fms_wrap(blk_base, cur_wptr & blk_mask);
    wire [8:0] a_addr = fms_wrap(blk_base, (rd_newest - tap_k) & blk_mask);
    wire [8:0] b_addr = fms_wrap(blk_base, (rd_newest - tap_m) & blk_mask);
    fms_pkg::fms_cplx_t sa;
    fms_pkg::fms_cplx_t sb;
    assign sa = dram[a_addr];
    assign sb = dram[b_addr];
    wire [7:0] c_idx = coef_base + calc_cnt[7:0];
    wire signed [15:0] c_ram = (c_idx < 8'(fms_pkg::CRAM_DEPTH)) ? cram[c_idx] : 16'sh0000;
    wire signed [15:0] coef = (ftype == fms_pkg::FT_SYM) ? c_ram : fms_pkg::ROM_COEF;
    wire signed [16:0] pre_re = {sa.re[15], sa.re} + (b_use ? {sb.re[15], sb.re} : 17'sh00000);
    wire signed [16:0] pre_im = {sa.im[15], sa.im} + (b_use ? {sb.im[15], sb.im} : 17'sh00000);
    wire signed [32:0] prod_re = pre_re * coef;
    wire signed [32:0] prod_im = pre_im * coef;
    wire first = calc_cnt == 9'h000;
    wire signed [39:0] next_acc_re = (first ? 40'sh0000000000 : acc_re) + 40'(prod_re);
    wire signed [39:0] next_acc_im = (first ? 40'sh0000000000 : acc_im) + 40'(prod_im);
    fms_pkg::fms_cplx_t result;
    assign result.re = next_acc_re[fms_pkg::OUT_SHIFT +: 16];
    assign result.im = next_acc_im[fms_pkg::OUT_SHIFT +: 16];
    wire sink_ok = to_out ? (~out_valid_o | out_ready_i) : ch_ready;
    wire emit = in_calc & calc_end & sink_ok;
    wire emit_out = emit & to_out;
    wire fir_done = emit & (out_cnt == nout_c - 4'h1);

    fms_fifo #(.W($bits(fms_pkg::fms_cplx_t)), .DEPTH(FIFO_DEPTH)) u_chain_fifo (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .clk_en_i(clk_en_i),
        .clear_i(filter_reset_i),
        .in_valid_i(emit & ~to_out),
        .in_data_i(result),
        .in_ready_o(ch_ready),
        .out_valid_o(ch_valid),
        .out_data_o(ch_data),
        .out_ready_i(ch_pop)
    );

    always_ff @(posedge clock_i) begin
        if (clk_en_i && wr_go) begin
            dram[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            acc_re <= 40'sh0000000000;
            acc_im <= 40'sh0000000000;
        end else if (clk_en_i && in_calc) begin
            acc_re <= next_acc_re;
            acc_im <= next_acc_im;
        end
    end

    // ----------------------------------------
    // sequencing
    // ----------------------------------------
    // one-clock flow steps
    wire flow_done = in_step & ((is_wait & cond) | is_jump | (is_fir & ~fir_start));
    wire step_done = flow_done | fir_done;
    wire [4:0] next_ip = (is_jump & cond) ? op[7:3] : step_o + 5'h01;
    wire flags_now = step_done & is_fir;
    wire dec_rst = flags_now & op[fms_pkg::F_DECR_EN] & op[fms_pkg::F_DECR_SEL];
    wire dec_sub = flags_now & op[fms_pkg::F_DECR_EN] & ~op[fms_pkg::F_DECR_SEL];
    wire [9:0] wc_sub = (wait_count_o >= wait_threshold_i) ? wait_count_o - wait_threshold_i : 10'h000;
    wire [9:0] wc_base = dec_rst ? 10'h000 : dec_sub ? wc_sub : wait_count_o;
    wire [9:0] next_wait = (in_push && wc_base != 10'h3FF) ? wc_base + 10'h001 : wc_base;
    wire [9:0] next_loop = (flags_now & op[fms_pkg::F_LD_LP]) ? loop_pre
        : (flags_now & op[fms_pkg::F_DECR_LP] & (loop_cnt != 10'h000)) ? loop_cnt - 10'h001 : loop_cnt;
    wire [8:0] next_calc = emit ? 9'h000 : (in_calc & ~calc_end) ? calc_cnt + 9'h001 : calc_cnt;

    fms_pkg::fms_state_t next_st;
    always_comb begin
        next_st = st;
        case (st)
            fms_pkg::S_HOLD: next_st = host_ram_access_hold_i ? fms_pkg::S_HOLD : fms_pkg::S_STEP;
            fms_pkg::S_STEP: next_st = (wr_last | no_wr) ? fms_pkg::S_CALC : fms_pkg::S_STEP;
            fms_pkg::S_CALC: next_st = emit ? fms_pkg::S_STEP : fms_pkg::S_CALC;
            default: next_st = fms_pkg::S_HOLD;
        endcase
        if (host_ram_access_hold_i || filter_reset_i) begin
            next_st = fms_pkg::S_HOLD;
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st <= fms_pkg::S_HOLD;
            step_o <= fms_pkg::IP_RESET;
        end else if (clk_en_i) begin
            st <= next_st;
            if (filter_reset_i) begin
                step_o <= fms_pkg::IP_RESET;
            end else if (step_done) begin
                step_o <= next_ip;
            end
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_cnt <= 4'h0;
            calc_cnt <= 9'h000;
            out_cnt <= 4'h0;
        end else if (clk_en_i) begin
            wr_cnt <= (!run || wr_last) ? 4'h0 : wr_go ? wr_cnt + 4'h1 : wr_cnt;
            calc_cnt <= run ? next_calc : 9'h000;
            out_cnt <= (!run || fir_done) ? 4'h0 : emit ? out_cnt + 4'h1 : out_cnt;
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wait_count_o <= 10'h000;
            loop_cnt <= 10'h000;
        end else if (clk_en_i) begin
            wait_count_o <= filter_reset_i ? 10'h000 : next_wait;
            loop_cnt <= filter_reset_i ? 10'h000 : next_loop;
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < fms_pkg::STEPS; i++) begin
                wptr[i] <= 8'h00;
            end
        end else if (clk_en_i) begin
            if (filter_reset_i) begin
                for (int i = 0; i < fms_pkg::STEPS; i++) begin
                    wptr[i] <= 8'h00;
                end
            end else if (wr_go) begin
                wptr[step_o] <= (cur_wptr + 8'h01) & blk_mask;
            end
        end
    end

    // ----------------------------------------
    // outputs, gain and sync
    // ----------------------------------------
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            out_valid_o <= 1'b0;
            out_o <= '0;
        end else if (clk_en_i) begin
            if (emit_out) begin
                out_valid_o <= 1'b1;
                out_o.data <= result;
                out_o.phase <= phase_i;
            end else if (out_ready_i || filter_reset_i) begin
                out_valid_o <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            forward_gain_o <= 16'h0000;
            gain_err_en_o <= 1'b0;
            agc_seq <= 2'h0;
            resampler_step_o <= 1'b0;
        end else if (clk_en_i) begin
            forward_gain_o <= share_gain_i ? shared_gain_i : own_gain_i;
            gain_err_en_o <= emit_out & (~share_gain_i | (agc_seq == 2'h0));
            agc_seq <= filter_reset_i ? 2'h0 : emit_out ? agc_seq + 2'h1 : agc_seq;
            resampler_step_o <= emit & op[fms_pkg::F_INCR_RS];
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sync_meta <= 1'b0;
            sync_s <= 1'b0;
        end else if (clk_en_i) begin
            sync_meta <= sync_i;
            sync_s <= sync_meta;
        end
    end
endmodule

/* File: tb/fms_sequencer_monitor.sv */
// port checker of the fir microcode sequencer
`timescale 1ns/1ns
module fms_seq_monitor (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic clk_en_i,
    input wire logic filter_reset_i,
    input wire logic host_ram_access_hold_i,
    input wire logic [3:0] chan_id_i,
    input wire logic host_rd_i,
    input wire fms_pkg::fms_host_t host_req_i,
    input wire logic host_rvalid_o,
    input wire logic [15:0] own_gain_i,
    input wire logic [15:0] shared_gain_i,
    input wire logic share_gain_i,
    input wire logic [15:0] forward_gain_o,
    input wire logic [4:0] step_o,
    input wire logic [9:0] wait_count_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    sequence rd_taken;
        host_rd_i && clk_en_i && host_ram_access_hold_i && host_req_i.addr[15:7] == {chan_id_i, 5'h02};
    endsequence
    ip_reset_a: assert property (filter_reset_i && clk_en_i |=> step_o == 5'h1F)
        else $error("pointer not reset");
    wait_clear_a: assert property (filter_reset_i && clk_en_i |=> wait_count_o == 10'h000)
        else $error("wait count kept");
    read_answer_a: assert property (rd_taken |=> host_rvalid_o)
        else $error("read unanswered");
    hold_refuse_a: assert property (host_rd_i && clk_en_i && !host_ram_access_hold_i |=> !host_rvalid_o)
        else $error("read without hold");
    answer_cause_a: assert property ($rose(host_rvalid_o) |-> $past(host_ram_access_hold_i))
        else $error("answer without hold");
    hold_freeze_a: assert property (host_ram_access_hold_i && $past(host_ram_access_hold_i)
        && clk_en_i && !filter_reset_i |=> $stable(step_o)) else $error("step moved in hold");
    gain_share_a: assert property (share_gain_i && clk_en_i |=> forward_gain_o == $past(shared_gain_i))
        else $error("shared gain lost");
    gain_own_a: assert property (!share_gain_i && clk_en_i |=> forward_gain_o == $past(own_gain_i))
        else $error("own gain lost");
endmodule
bind fms_sequencer fms_seq_monitor mon_u (.*);

/* File: tb/fms_sample_src.sv */
// upstream sample source model
`timescale 1ns/1ns
module fms_sample_src (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic start_i,
    input wire logic ready_i,
    output logic valid_o,
    output fms_pkg::fms_cplx_t data_o
);
    logic [7:0] left;
    assign valid_o = left != 8'h00;
    assign data_o = valid_o ? {2{8'h00, left}} : {2{8'hFF, ~left}};
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) left <= 8'h00;
        else if (start_i) left <= 8'h03;
        else if (valid_o && ready_i) left <= left - 8'h01;
    end
endmodule

/* File: tb/fms_sequencer_tb_top.sv */
// self-checking testbench of the fir microcode sequencer
`timescale 1ns/1ns
module fms_sequencer_tb_top;
    logic clock_i = 1'b0, rst_n_i = 1'b0, clk_en_i = 1'b1, filter_reset_i = 1'b0, host_ram_access_hold_i = 1'b1;
    logic host_wr_i = 1'b0, host_rd_i = 1'b0, sync_i = 1'b0, sync_en_i = 1'b0, host_cond_i = 1'b0, start = 1'b0;
    logic resampler_carry_out_i = 1'b0, out_ready_i = 1'b0, share_gain_i = 1'b0;
    logic [3:0] chan_id_i = 4'h5;
    logic [1:0] phase_i = 2'h2;
    logic [7:0] read_offset_i = 8'h00;
    logic [9:0] wait_threshold_i = 10'h003, wait_count_o;
    logic [15:0] own_gain_i = 16'h0100, shared_gain_i = 16'h0A5A, forward_gain_o;
    fms_pkg::fms_host_t host_req_i = '0;
    fms_pkg::fms_cplx_t sample_i;
    fms_pkg::fms_out_t out_o;
    logic [31:0] host_rdata_o;
    logic host_rvalid_o, sample_valid_i, sample_ready_o, out_valid_o, gain_err_en_o, resampler_step_o;
    logic [4:0] step_o;
    logic [4:0] step_num [4] = '{5'h1F, 5'h00, 5'h01, 5'h02};
    logic [127:0] prog [4] = '{128'h080, 128'h001, 128'h00040000_011802E0, 128'h104};
    int miscompares = 0, num_checks = 0, gain_pulses = 0, rs_pulses = 0;
    always #20 clock_i = ~clock_i;
    always @(posedge clock_i) begin
        if (gain_err_en_o === 1'b1) gain_pulses++;
        if (resampler_step_o === 1'b1) rs_pulses++;
    end
    fms_sequencer dut_u (.*);
    fms_sample_src src_u (.clock_i, .rst_n_i, .start_i(start), .ready_i(sample_ready_o), .valid_o(sample_valid_i),
        .data_o(sample_i));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic acc(input logic rd, input logic [3:0] ch, input logic [6:0] sl, input logic [31:0] d);
        @(posedge clock_i);
        host_rd_i <= rd;
        host_wr_i <= !rd;
        host_req_i <= {ch, 5'h02, sl, d};
        @(posedge clock_i);
        host_rd_i <= 1'b0;
        host_wr_i <= 1'b0;
        #1;
    endtask
    task automatic print_verdict;
        $display("checks=%0d mismatches=%0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge clock_i);
        rst_n_i <= 1'b1;
        @(posedge clock_i);
        #1;
        chk(32'(step_o), 32'h1F);
        for (int l = 0; l < 4; l++) acc(1'b0, 4'h5, {5'h05, 2'(l)}, 32'hA500 + 32'(l));
        for (int l = 0; l < 4; l++) begin
            acc(1'b1, 4'h5, {5'h05, 2'(l)}, 32'h0);
            chk(host_rdata_o, 32'hA500 + 32'(l));
        end
        acc(1'b1, 4'h6, 7'h14, 32'h0);
        chk(32'(host_rvalid_o), 32'h0);
        for (int s = 0; s < 4; s++)
            for (int l = 0; l < 4; l++) acc(1'b0, 4'h5, {step_num[s], 2'(l)}, prog[s][32*l +: 32]);
        $display("test host access done");
        host_ram_access_hold_i <= 1'b0;
        acc(1'b1, 4'h5, 7'h14, 32'h0);
        chk(32'(host_rvalid_o), 32'h0);
        repeat (10) @(posedge clock_i);
        #1;
        chk(32'(step_o), 32'h0);
        start <= 1'b1;
        share_gain_i <= 1'b1;
        @(posedge clock_i);
        start <= 1'b0;
        repeat (30) @(posedge clock_i);
        #1;
        chk(32'(wait_count_o), 32'h3);
        chk(32'(step_o), 32'h1);
        chk(out_o.data, 32'h00030003);
        chk(32'(out_o.phase), 32'h2);
        chk(32'(forward_gain_o), 32'h0A5A);
        chk(32'(out_valid_o), 32'h1);
        @(posedge clock_i);
        out_ready_i <= 1'b1;
        repeat (20) @(posedge clock_i);
        #1;
        chk(out_o.data, 32'h00010001);
        chk(32'(out_valid_o), 32'h0);
        chk(32'(gain_pulses), 32'h1);
        chk(32'(rs_pulses), 32'h3);
        chk(32'(sample_ready_o), 32'h1);
        $display("test program run done");
        filter_reset_i <= 1'b1;
        share_gain_i <= 1'b0;
        @(posedge clock_i);
        filter_reset_i <= 1'b0;
        #1;
        chk(32'(step_o), 32'h1F);
        chk(32'(wait_count_o), 32'h0);
        chk(32'(forward_gain_o), 32'h0100);
        $display("test filter reset done");
        print_verdict;
    end
    initial begin
        repeat (3000) @(posedge clock_i);
        miscompares++;
        print_verdict;
    end
endmodule
